// File: pkg/ssie_pkg.sv
// constants and types for the set-all-ones and power-down execution block
// What this block does
// - With the bank operand bit at one, the set-all-ones target lies in the bank named by bank_select_reg, the default case.
// - Set-all-ones writes FFh to the addressed register and touches no status flag.
// - The word 0003h, all zero but the two low bits, decodes as the power-down instruction.
// - Power-down clears powerdown_flag.
// - Power-down sets timeout_flag.
// - Power-down clears the watchdog counter and its postscaler.
// - Power-down puts the core to sleep and halts the oscillator.
// - A watchdog wake-up from sleep clears timeout_flag.
// - Power-down changes only timeout_flag and powerdown_flag, never the arithmetic flags.
package ssie_pkg;
	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [15:0] SSIE_SLEEP_OPCODE = 16'h0003;
	localparam logic [6:0]  SSIE_SET_ALL_ONES_OP_PREFIX  = 7'h34;
	localparam int          SSIE_SET_ALL_ONES_OP_LSB     = 9;
	localparam int          SSIE_ABIT_POS     = 8;
	// ****************************************
	// data and reset values
	// ****************************************
	localparam logic [7:0]  SSIE_ALL_ONES     = 8'hFF;
	localparam logic [3:0]  SSIE_ACCESS_BANK  = 4'h0;
	localparam logic        SSIE_TO_RST       = 1'b1;
	localparam logic        SSIE_PD_RST       = 1'b1;

	typedef enum logic [1:0] {
		SSIE_Q1 = 2'b00,
		SSIE_Q2 = 2'b01,
		SSIE_Q3 = 2'b10,
		SSIE_Q4 = 2'b11
	} ssie_phase_t;
endpackage : ssie_pkg

// File: src/ssie_phase_gen.sv
// quarter-phase sequencer for the core clock
`timescale 1ns/1ps
module ssie_phase_gen (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// run control
	input  wire logic               halt,
	// phase out
	output ssie_pkg::ssie_phase_t   phase
);
	ssie_pkg::ssie_phase_t phase_q;
	ssie_pkg::ssie_phase_t phase_d;

	// halted sequencer parks in Q1 so wake-up starts a fresh cycle
	always_comb begin
		case (phase_q)
			ssie_pkg::SSIE_Q1: phase_d = ssie_pkg::SSIE_Q2;
			ssie_pkg::SSIE_Q2: phase_d = ssie_pkg::SSIE_Q3;
			ssie_pkg::SSIE_Q3: phase_d = ssie_pkg::SSIE_Q4;
			ssie_pkg::SSIE_Q4: phase_d = ssie_pkg::SSIE_Q1;
			default:           phase_d = ssie_pkg::SSIE_Q1;
		endcase
		if (halt) begin
			phase_d = ssie_pkg::SSIE_Q1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_q <= ssie_pkg::SSIE_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase = phase_q;
endmodule : ssie_phase_gen

// File: src/ssie_exec.sv
// execution of the set-all-ones and power-down instructions
`timescale 1ns/1ps
module ssie_exec (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// instruction from decode, held through the cycle
	input  wire logic [15:0] instrWord,
	input  wire logic        instrValid,
	// bank select register value
	input  wire logic [3:0]  bankSelectReg,
	// wake-up causes
	input  wire logic        wakeWatchdog,
	input  wire logic        wakeOther,
	// data memory write port
	output logic             memWrEn,
	output logic [11:0]      memWrAddr,
	output logic [7:0]       memWrData,
	// status flags
	output logic             timeoutFlag,
	output logic             powerdownFlag,
	output logic             arithFlagWrEn,
	// watchdog control
	output logic             watchdogClr,
	// power control
	output logic             sleepActive,
	output logic             oscHalt,
	// phase of the instruction cycle
	output logic [1:0]       phaseOut
);
	// ****************************************
	// phase sequencing
	// ****************************************
	ssie_pkg::ssie_phase_t phase;
	logic                  sleep_q;

	ssie_phase_gen u_phase (
		.clk   (clk),
		.srst  (srst),
		.halt  (sleep_q),
		.phase (phase)
	);

	// ****************************************
	// decode
	// ****************************************
	wire isSleep = instrValid && !sleep_q &&
		(instrWord == ssie_pkg::SSIE_SLEEP_OPCODE);
	wire isSetf  = instrValid && !sleep_q &&
		(instrWord[15:ssie_pkg::SSIE_SET_ALL_ONES_OP_LSB] ==
		 ssie_pkg::SSIE_SET_ALL_ONES_OP_PREFIX);
	wire bankBit = instrWord[ssie_pkg::SSIE_ABIT_POS];
	// a=1 uses the bank select register, a=0 the access bank
	wire [3:0] tgtBank = bankBit ? bankSelectReg :
		ssie_pkg::SSIE_ACCESS_BANK;
	wire [11:0] tgtAddr = {tgtBank, instrWord[7:0]};

	wire inQ3 = (phase == ssie_pkg::SSIE_Q3);
	wire inQ4 = (phase == ssie_pkg::SSIE_Q4);
	wire wakeAny = sleep_q && (wakeWatchdog || wakeOther);

	// ****************************************
	// state
	// ****************************************
	logic        memWrEn_q, watchdogClr_q, to_q, pd_q;
	logic [11:0] memWrAddr_q;
	logic [1:0]  phase_q;
	// constant outputs still leave from flops, so no path runs from decode
	logic [7:0]  memWrData_q;
	logic        arithFlagWrEn_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			memWrEn_q   <= 1'b0;
			memWrAddr_q <= 12'h000;
			watchdogClr_q <= 1'b0;
			to_q        <= ssie_pkg::SSIE_TO_RST;
			pd_q        <= ssie_pkg::SSIE_PD_RST;
			sleep_q     <= 1'b0;
			phase_q     <= 2'h0;
			memWrData_q <= ssie_pkg::SSIE_ALL_ONES;
			arithFlagWrEn_q <= 1'b0;
		end else begin
			memWrData_q <= ssie_pkg::SSIE_ALL_ONES;
			arithFlagWrEn_q <= 1'b0;
			// write lands in Q4 of set-all-ones
			memWrEn_q   <= isSetf && inQ3;
			memWrAddr_q <= tgtAddr;
			// watchdog and postscaler clear pulse lands in Q4 of power-down
			watchdogClr_q <= isSleep && inQ3;
			if (isSleep && inQ3) begin
				to_q <= 1'b1;
				pd_q <= 1'b0;
			end else if (wakeAny && wakeWatchdog) begin
				to_q <= 1'b0;
			end
			if (isSleep && inQ4) begin
				sleep_q <= 1'b1;
			end else if (wakeAny) begin
				sleep_q <= 1'b0;
			end
			phase_q <= phase;
		end
	end

	assign memWrEn       = memWrEn_q;
	assign memWrAddr     = memWrAddr_q;
	assign memWrData     = memWrData_q;
	// neither instruction touches the arithmetic flags
	assign arithFlagWrEn = arithFlagWrEn_q;
	assign timeoutFlag   = to_q;
	assign powerdownFlag = pd_q;
	assign watchdogClr   = watchdogClr_q;
	assign sleepActive   = sleep_q;
	assign oscHalt       = sleep_q;
	assign phaseOut      = phase_q;

	// ****************************************
	// checks
	// ****************************************
	sleep_flags_a: assert property (@(posedge clk) disable iff (srst)
		(isSleep && inQ3) |=> (!pd_q && to_q && watchdogClr_q))
		else $error("power-down did not update flags");
	sleep_entry_a: assert property (@(posedge clk) disable iff (srst)
		(isSleep && inQ3) |=> ##1 sleep_q)
		else $error("sleep not entered after Q4");
	osc_halt_a: assert property (@(posedge clk) disable iff (srst)
		sleep_q |-> oscHalt)
		else $error("oscillator runs in sleep");
	wdt_wake_a: assert property (@(posedge clk) disable iff (srst)
		(sleep_q && wakeWatchdog) |=> (!to_q && !sleep_q))
		else $error("watchdog wake did not clear time-out");
	set_all_ones_op_write_a: assert property (@(posedge clk) disable iff (srst)
		(isSetf && inQ3) |=>
		(memWrEn_q && memWrData == ssie_pkg::SSIE_ALL_ONES))
		else $error("set-all-ones write missing");
	bank_sel_a: assert property (@(posedge clk) disable iff (srst)
		(isSetf && inQ3 && bankBit) |=>
		(memWrAddr_q[11:8] == $past(bankSelectReg)))
		else $error("bank select not used");
	decode_a: assert property (@(posedge clk) disable iff (srst)
		(instrValid && !sleep_q && inQ3 &&
		 instrWord == ssie_pkg::SSIE_SLEEP_OPCODE)
		|=> watchdogClr_q)
		else $error("power-down opcode not decoded");
	no_arith_a: assert property (@(posedge clk) disable iff (srst)
		!arithFlagWrEn)
		else $error("arithmetic flags written");
	wdt_only_a: assert property (@(posedge clk) disable iff (srst)
		watchdogClr_q |-> $past(isSleep))
		else $error("stray watchdog clear");

	// ****************************************
	// flag hold checks
	// ****************************************
	// powerdown_flag only ever falls outside reset
	pd_hold_a: assert property (@(posedge clk) disable iff (srst)
		!(isSleep && inQ3) |=> $stable(pd_q))
		else $error("powerdown flag moved without power-down");
	to_hold_a: assert property (@(posedge clk) disable iff (srst)
		(!(isSleep && inQ3) && !(sleep_q && wakeWatchdog)) |=>
		$stable(to_q))
		else $error("timeout flag moved without cause");
	// a wake from any other source leaves the timeout flag alone
	other_wake_a: assert property (@(posedge clk) disable iff (srst)
		(sleep_q && wakeOther && !wakeWatchdog) |=>
		(!sleep_q && $stable(to_q)))
		else $error("other wake mishandled");

	// ****************************************
	// sleep checks
	// ****************************************
	// parked sequencer keeps wake-up aligned to Q1
	phase_park_a: assert property (@(posedge clk) disable iff (srst)
		sleep_q |-> (phase == ssie_pkg::SSIE_Q1))
		else $error("phase runs during sleep");
	asleep_quiet_a: assert property (@(posedge clk) disable iff (srst)
		sleep_q |=> (!memWrEn_q && !watchdogClr_q))
		else $error("activity while asleep");

	// ****************************************
	// pulse and address checks
	// ****************************************
	wr_pulse_a: assert property (@(posedge clk) disable iff (srst)
		memWrEn_q |=> !memWrEn_q)
		else $error("write pulse stretched");
	clr_pulse_a: assert property (@(posedge clk) disable iff (srst)
		watchdogClr_q |=> !watchdogClr_q)
		else $error("watchdog clear stretched");
	access_bank_a: assert property (@(posedge clk) disable iff (srst)
		(isSetf && inQ3 && !bankBit) |=>
		(memWrAddr_q[11:8] == ssie_pkg::SSIE_ACCESS_BANK))
		else $error("access bank not used");
	set_all_ones_op_addr_a: assert property (@(posedge clk) disable iff (srst)
		(isSetf && inQ3) |=>
		(memWrAddr_q[7:0] == $past(instrWord[7:0])))
		else $error("register offset lost");
endmodule : ssie_exec

// File: dv/ssie_core_model.sv
// memory and watchdog stand-in that records what the block drives
`timescale 1ns/1ps
module ssie_core_model (
	// clock
	clk,
	// write port and watchdog clear
	memWrEn, memWrAddr, memWrData, watchdogClr,
	// recorded activity
	wrCount, clrCount, lastAddr, lastData
);
	input  wire logic        clk;
	input  wire logic        memWrEn;
	input  wire logic [11:0] memWrAddr;
	input  wire logic [7:0]  memWrData;
	input  wire logic        watchdogClr;
	output logic      [7:0]  wrCount = 8'h00;
	output logic      [7:0]  clrCount = 8'h00;
	output logic      [11:0] lastAddr = 12'h000;
	output logic      [7:0]  lastData = 8'h00;
	// one count per cycle held high, so a stretched pulse shows
	always @(posedge clk) begin
		if (memWrEn) begin
			wrCount  <= wrCount + 8'h01;
			lastAddr <= memWrAddr;
			lastData <= memWrData;
		end
		if (watchdogClr)
			clrCount <= clrCount + 8'h01;
	end
endmodule : ssie_core_model

// File: dv/tb.sv
// self-checking bench for the set-all-ones and power-down block
`timescale 1ns/1ps
module tb;
	logic        clk, srst, instrValid, wakeWatchdog, wakeOther;
	logic        memWrEn, timeoutFlag, powerdownFlag, arithFlagWrEn;
	logic        watchdogClr, sleepActive, oscHalt;
	logic [15:0] instrWord;
	logic [3:0]  bankSelectReg;
	logic [11:0] memWrAddr, lastAddr;
	logic [7:0]  memWrData, lastData, wrCount, clrCount;
	logic [1:0]  phaseOut;
	int          n_fail, num_checks;
	ssie_exec u_ssie_exec (.clk, .srst, .instrWord, .instrValid,
		.bankSelectReg, .wakeWatchdog, .wakeOther, .memWrEn, .memWrAddr,
		.memWrData, .timeoutFlag, .powerdownFlag, .arithFlagWrEn,
		.watchdogClr, .sleepActive, .oscHalt, .phaseOut);
	ssie_core_model u_ssie_core_model (.clk, .memWrEn, .memWrAddr,
		.memWrData, .watchdogClr, .wrCount, .clrCount, .lastAddr, .lastData);
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// present a word from Q1, judge the Q4 pulses, then drop valid
	task automatic issue(input logic [15:0] w, input logic wr, clr);
		int i;
		for (i = 0; i < 20 && phaseOut !== 2'h2; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 20)
			end_sim();
		@(posedge clk);
		instrWord  <= w;
		instrValid <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("memWrEn", memWrEn, wr);
		chk("watchdogClr", watchdogClr, clr);
		chk("arithFlagWrEn", arithFlagWrEn, 1'b0);
		chk("phaseOut", phaseOut, 2'h2);
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
	endtask : issue
	task automatic t_set_all_ones_op(input logic a);
		issue({7'h34, a, 8'hA5}, 1'b1, 1'b0);
		chk("lastAddr", lastAddr, {a ? 4'h5 : 4'h0, 8'hA5});
		chk("lastData", lastData, 8'hFF);
		chk("powerdownFlag", powerdownFlag, 1'b1);
	endtask : t_set_all_ones_op
	task automatic t_sleep(input logic wd, expTo);
		issue(16'h0003, 1'b0, 1'b1);
		chk("oscHalt", {sleepActive, oscHalt}, 2'h3);
		chk("flags", {timeoutFlag, powerdownFlag}, 2'h2);
		chk("powerdownFlag", powerdownFlag, 1'b0);
		// ignored while asleep
		@(posedge clk);
		instrWord  <= 16'h69A5;
		instrValid <= 1'b1;
		repeat (6) @(posedge clk);
		instrValid   <= 1'b0;
		wakeWatchdog <= wd;
		wakeOther    <= !wd;
		@(posedge clk);
		wakeWatchdog <= 1'b0;
		wakeOther    <= 1'b0;
		#1;
		chk("sleepActive", sleepActive, 1'b0);
		chk("timeoutFlag", timeoutFlag, expTo);
	endtask : t_sleep
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{srst, instrValid, wakeWatchdog, wakeOther} = 4'h8;
		instrWord     = 16'h0000;
		bankSelectReg = 4'h5;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk("flags", {timeoutFlag, powerdownFlag}, 2'h3);
		t_set_all_ones_op(1'b1);
		t_set_all_ones_op(1'b0);
		issue(16'h0002, 1'b0, 1'b0);
		issue(16'h0007, 1'b0, 1'b0);
		chk("sleepActive", sleepActive, 1'b0);
		t_sleep(1'b1, 1'b0);
		t_sleep(1'b0, 1'b1);
		chk("wrCount", wrCount, 8'h02);
		chk("clrCount", clrCount, 8'h02);
		end_sim();
	end
endmodule : tb
